// File: rtl/mpd_params.svh
// Constants for the motor pre-driver input control block.
// Assumes a 100 MHz system clock; included by rtl/mpd_ctrl.sv, not by rtl/mpd_pkg.sv.
`ifndef MPD_PARAMS_SVH
`define MPD_PARAMS_SVH

`define MPD_CLK_MHZ 100
`define MPD_PWRUP_MIN_US 1000
`define MPD_PWRUP_MAX_US 2000
`define MPD_PWRUP_MIN_CYC (`MPD_PWRUP_MIN_US * `MPD_CLK_MHZ)
`define MPD_PWRUP_MAX_CYC (`MPD_PWRUP_MAX_US * `MPD_CLK_MHZ)
`define MPD_US_DIV `MPD_CLK_MHZ
`define MPD_PWRUP_US_CNT `MPD_PWRUP_MIN_US
`define MPD_LOW_PULSE_NS 1000
`define MPD_LOW_PULSE_CYC ((`MPD_LOW_PULSE_NS * `MPD_CLK_MHZ + 999) / 1000)
`define MPD_CNT_W 18
`define MPD_GATE_RST 6'h00

`endif

// File: rtl/mpd_pkg.sv
// Types for the motor pre-driver input control block.
// Assumes nothing of its surroundings.
package mpd_pkg;

    typedef enum logic [1:0] {
        MPD_ST_OFF = 2'b00,
        MPD_ST_WAIT_SUPPLY = 2'b01,
        MPD_ST_PWRUP = 2'b10,
        MPD_ST_RUN = 2'b11
    } mpd_state_t;

    // Six gate drives, one bit per gate
    typedef struct packed {
        logic high_gate_phase_c;
        logic high_gate_phase_b;
        logic high_gate_phase_a;
        logic low_gate_phase_c;
        logic low_gate_phase_b;
        logic low_gate_phase_a;
    } mpd_gates_t;

    // Three hall sensor levels
    typedef struct packed {
        logic hall_sense_a;
        logic hall_sense_b;
        logic hall_sense_c;
    } mpd_hall_t;

endpackage

// File: rtl/mpd_ctrl.sv
// Control logic of a three-phase gate pre-driver: power-up gate, sleep, brake and commutation.
// Assumes all inputs are pins from outside this clock domain; gate outputs feed external drivers.
//
// Overview of operation
// - Power-up starts only while the supply lockout comparator reports the supply good.
// - After power-up starts, nothing works until the gate supply good flag is seen high.
// - The power-up interval lasts 1 to 2 ms, then inputs are obeyed and gates driven.
// - A low sleep control input puts the block into sleep.
// - In sleep every function including the gate outputs is disabled.
// - While sleep control is low, brake, pulse-width, direction and halls are ignored.
// - Leaving sleep reruns the whole power-up sequence including the supply wait.
// - A low brake input turns on all three low-side gates whatever the pulse-width.
// - With brake off and pulse-width low the selected phase is driven low.
// - With brake off and pulse-width high the selected phase is driven high.
// - The direction input picks rotation sense, changing the selected phase.
// - The selected phases come from three 120 degree Hall inputs and direction.
// - On each Hall change the newly driven phase is held low briefly first.
`timescale 1ns/100ps
`include "mpd_params.svh"

module mpd_ctrl (
    input wire logic sys_clk_i,                // 100 MHz clock
    input wire logic arst_n_i,                 // Async reset, active low
    input wire logic supply_ok_i,              // Main supply above lockout threshold
    input wire logic gate_supply_ok_i,         // Gate supply above rising threshold
    input wire logic sleep_ctl_n_i,            // Sleep control, low sleeps
    input wire logic brake_in_n_i,             // Brake, active low
    input wire logic pwm_i,                    // Pulse-width input
    input wire logic dir_i,                    // Rotation direction
    input wire mpd_pkg::mpd_hall_t hall_i,     // Hall sensor levels
    output mpd_pkg::mpd_gates_t gates_o,       // Six gate drives, registered
    output logic ready_o                       // Power-up done, registered
);
    import mpd_pkg::*;

    localparam logic [`MPD_CNT_W-1:0] PWRUP_TICKS = `MPD_CNT_W'(`MPD_PWRUP_US_CNT);
    localparam logic [6:0] US_DIV_LAST = 7'(`MPD_US_DIV - 1);
    localparam logic [`MPD_CNT_W-1:0] LOW_CYC = `MPD_CNT_W'(`MPD_LOW_PULSE_CYC);

    // Phase drive code: 2 = driven by pwm, 1 = low side on, 0 = off
    typedef logic [1:0] mpd_drv_t;

    // Commutation lookup; returns drive codes for phases c,b,a
    function automatic logic [5:0] commutate(input logic [2:0] h, input logic d);
        logic [5:0] r;
        r = 6'h00;
        if (d) begin
            unique case (h)
                3'b101: r = {2'd1, 2'd0, 2'd2};
                3'b100: r = {2'd1, 2'd2, 2'd0};
                3'b110: r = {2'd0, 2'd2, 2'd1};
                3'b010: r = {2'd2, 2'd0, 2'd1};
                3'b011: r = {2'd2, 2'd1, 2'd0};
                3'b001: r = {2'd0, 2'd1, 2'd2};
                default: r = 6'h00;
            endcase
        end else begin
            unique case (h)
                3'b101: r = {2'd2, 2'd0, 2'd1};
                3'b100: r = {2'd2, 2'd1, 2'd0};
                3'b110: r = {2'd0, 2'd1, 2'd2};
                3'b010: r = {2'd1, 2'd0, 2'd2};
                3'b011: r = {2'd1, 2'd2, 2'd0};
                3'b001: r = {2'd0, 2'd2, 2'd1};
                default: r = 6'h00;
            endcase
        end
        return r;
    endfunction

    // Codes 000 and 111 never come from a sound sensor set
    function automatic logic hall_valid(input logic [2:0] h);
        return (h != 3'h0) && (h != 3'h7);
    endfunction

    // Gate pair {high, low} of one phase for its drive code
    function automatic logic [1:0] phase_pair(input mpd_drv_t code, input logic pwm_on);
        logic [1:0] g;
        g = 2'h0;
        unique case (code)
            2'd0: g = 2'h0;
            2'd1: g = 2'h1;
            2'd2: g = {pwm_on, !pwm_on};
            default: g = 2'h0;
        endcase
        return g;
    endfunction

    // Never both gates of one leg; the low side wins a clash
    function automatic mpd_gates_t leg_guard(input mpd_gates_t g);
        mpd_gates_t r;
        r = g;
        r.high_gate_phase_a = g.high_gate_phase_a && !g.low_gate_phase_a;
        r.high_gate_phase_b = g.high_gate_phase_b && !g.low_gate_phase_b;
        r.high_gate_phase_c = g.high_gate_phase_c && !g.low_gate_phase_c;
        return r;
    endfunction

    // Two-flop synchronisers, one set per pin group
    logic [1:0] sup_sync1_ff;
    logic [1:0] sup_sync2_ff;
    logic [3:0] ctl_sync1_ff;
    logic [3:0] ctl_sync2_ff;
    logic [2:0] hall_sync1_ff;
    logic [2:0] hall_sync2_ff;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sup_sync1_ff <= 2'h0;
            sup_sync2_ff <= 2'h0;
        end else begin
            sup_sync1_ff <= {supply_ok_i, gate_supply_ok_i};
            sup_sync2_ff <= sup_sync1_ff;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_sync1_ff <= 4'h0;
            ctl_sync2_ff <= 4'h0;
        end else begin
            ctl_sync1_ff <= {sleep_ctl_n_i, brake_in_n_i, pwm_i, dir_i};
            ctl_sync2_ff <= ctl_sync1_ff;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hall_sync1_ff <= 3'h0;
            hall_sync2_ff <= 3'h0;
        end else begin
            hall_sync1_ff <= hall_i;
            hall_sync2_ff <= hall_sync1_ff;
        end
    end

    logic s_supply;
    logic s_gsupply;
    logic s_awake;
    logic s_brake_n;
    logic s_pwm;
    logic s_dir;
    logic [2:0] s_hall;
    assign {s_supply, s_gsupply} = sup_sync2_ff;
    assign {s_awake, s_brake_n, s_pwm, s_dir} = ctl_sync2_ff;
    assign s_hall = hall_sync2_ff;

    // Power-up sequencer
    mpd_state_t state_ff;
    mpd_state_t nxt_state;
    logic [`MPD_CNT_W-1:0] pwr_cnt_ff;

    // One-cycle microsecond enable, restarted on entry to power-up
    logic [6:0] us_div_ff;
    logic us_tick;
    assign us_tick = (state_ff == MPD_ST_PWRUP) && (us_div_ff == US_DIV_LAST);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            us_div_ff <= 7'h00;
        end else if (state_ff != MPD_ST_PWRUP || us_tick) begin
            us_div_ff <= 7'h00;
        end else begin
            us_div_ff <= us_div_ff + 7'h01;
        end
    end

    // Sleep or lockout both force a full restart
    logic drop;
    assign drop = !s_supply || !s_awake;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            MPD_ST_OFF: begin
                if (s_supply && s_awake) begin
                    nxt_state = MPD_ST_WAIT_SUPPLY;
                end
            end
            MPD_ST_WAIT_SUPPLY: begin
                if (s_gsupply) begin
                    nxt_state = MPD_ST_PWRUP;
                end
            end
            MPD_ST_PWRUP: begin
                if (us_tick && pwr_cnt_ff == PWRUP_TICKS - `MPD_CNT_W'(1)) begin
                    nxt_state = MPD_ST_RUN;
                end
            end
            MPD_ST_RUN: begin
                nxt_state = MPD_ST_RUN;
            end
        endcase
        if (drop) begin
            nxt_state = MPD_ST_OFF;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= MPD_ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwr_cnt_ff <= '0;
        end else if (state_ff == MPD_ST_PWRUP && nxt_state == MPD_ST_PWRUP) begin
            if (us_tick) begin
                pwr_cnt_ff <= pwr_cnt_ff + `MPD_CNT_W'(1);
            end
        end else begin
            pwr_cnt_ff <= '0;
        end
    end

    logic run;
    assign run = (state_ff == MPD_ST_RUN) && (nxt_state == MPD_ST_RUN);

    // Hall change low pulse
    logic [2:0] hall_prev_ff;
    logic [`MPD_CNT_W-1:0] low_cnt_ff;
    logic hall_edge;
    assign hall_edge = (s_hall != hall_prev_ff);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hall_prev_ff <= 3'h0;
        end else begin
            hall_prev_ff <= s_hall;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_cnt_ff <= '0;
        end else if (run && hall_edge) begin
            low_cnt_ff <= LOW_CYC;
        end else if (low_cnt_ff != '0) begin
            low_cnt_ff <= low_cnt_ff - `MPD_CNT_W'(1);
        end
    end

    // Gate decode
    logic [5:0] drv;
    mpd_gates_t nxt_gates;
    logic pwm_eff;
    assign drv = commutate(s_hall, s_dir);
    assign pwm_eff = s_pwm && (low_cnt_ff == '0) && !hall_edge;

    always_comb begin
        logic [1:0] pair;
        pair = 2'h0;
        nxt_gates = `MPD_GATE_RST;
        if (!run) begin
            nxt_gates = `MPD_GATE_RST;
        end else if (!s_brake_n) begin
            nxt_gates = 6'h07;
        end else if (hall_valid(s_hall)) begin
            for (int p = 0; p < 3; p++) begin
                pair = phase_pair(drv[2*p +: 2], pwm_eff);
                nxt_gates[p+3] = pair[1];
                nxt_gates[p] = pair[0];
            end
        end
    end

    // Gate drives
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gates_o <= `MPD_GATE_RST;
        end else begin
            gates_o <= leg_guard(nxt_gates);
        end
    end

    // Running flag
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= run;
        end
    end

endmodule // mpd_ctrl

// File: dv/mpd_ctrl_assertions.sv
// Port checker for mpd_ctrl.
// Assumes the bind below; one clock domain.
`timescale 1ns/100ps
module mpd_ctrl_chk (
    input wire logic sys_clk_i, // Clock
    input wire logic arst_n_i, // Reset
    input wire logic supply_ok_i, // Supply
    input wire logic gate_supply_ok_i, // Gate supply
    input wire logic sleep_ctl_n_i, // Sleep
    input wire logic brake_in_n_i, // Brake
    input wire logic pwm_i, // Pwm
    input wire logic dir_i, // Dir
    input wire mpd_pkg::mpd_hall_t hall_i, // Halls
    input wire mpd_pkg::mpd_gates_t gates_o, // Gates
    input wire logic ready_o // Ready
);
    import mpd_pkg::*;
    localparam int PU_MIN = 100000;
    localparam int PU_MAX = 200000;
    logic [17:0] up_cnt_ff;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Cycles with all enables up before ready
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            up_cnt_ff <= '0;
        else if (supply_ok_i && gate_supply_ok_i && sleep_ctl_n_i && !ready_o)
            up_cnt_ff <= up_cnt_ff + 18'h1;
        else
            up_cnt_ff <= '0;
    end
    gates_idle_a: assert property (
        !ready_o && !$past(ready_o) |-> gates_o == 6'h00) else $error("gates on while idle");
    sleep_off_a: assert property (
        !sleep_ctl_n_i |-> ##5 (!ready_o && gates_o == 6'h00)) else $error("sleep ignored");
    supply_off_a: assert property (
        !supply_ok_i |-> ##5 (!ready_o && gates_o == 6'h00)) else $error("supply loss ignored");
    gsup_wait_a: assert property (
        !ready_o && !gate_supply_ok_i |=> !ready_o) else $error("ready without gate supply");
    pwrup_time_a: assert property (
        $rose(ready_o) |-> up_cnt_ff >= PU_MIN && up_cnt_ff <= PU_MAX) else $error("bad power-up");
    rerun_a: assert property (
        $rose(sleep_ctl_n_i) |=> !ready_o [*8]) else $error("no power-up after wake");
    brake_low_a: assert property (
        (ready_o && !brake_in_n_i) [*6] |-> gates_o == 6'h07) else $error("brake wrong");
    pulse_low_a: assert property (
        ready_o && brake_in_n_i && $changed(hall_i) |-> ##6 gates_o[5:3] == 3'b000)
        else $error("no low pulse");
endmodule // mpd_ctrl_chk

bind mpd_ctrl mpd_ctrl_chk u_chk (.sys_clk_i, .arst_n_i, .supply_ok_i, .gate_supply_ok_i,
    .sleep_ctl_n_i, .brake_in_n_i, .pwm_i, .dir_i, .hall_i, .gates_o, .ready_o);

// File: dv/mpd_host_model.sv
// Host model driving the control pins.
// Assumes bench requests change after a rising edge.
`timescale 1ns/100ps
module mpd_host_model (
    input wire logic sys_clk_i, // Clock
    input wire logic [3:0] req_i, // Sleep, brake, pwm, dir
    output logic [3:0] pins_o // Same order
);
    initial pins_o = 4'h0;
    always @(negedge sys_clk_i) pins_o <= req_i;
endmodule // mpd_host_model

// File: dv/mpd_ctrl_tb.sv
// Bench for mpd_ctrl.
// Assumes the checker is bound by its own file.
`timescale 1ns/100ps
module mpd_ctrl_tb;
    import mpd_pkg::*;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic supply_ok_i = 1'b0;
    logic gate_supply_ok_i = 1'b0;
    logic [3:0] req = 4'h4;
    logic sleep_ctl_n_i, brake_in_n_i, pwm_i, dir_i;
    logic [3:0] pins;
    assign {sleep_ctl_n_i, brake_in_n_i, pwm_i, dir_i} = pins;
    mpd_hall_t hall_i = 3'b001;
    mpd_gates_t gates_o;
    logic ready_o;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [2:0] seq [6] = '{3'b101, 3'b100, 3'b110, 3'b010, 3'b011, 3'b001};
    always #5 sys_clk_i = ~sys_clk_i;
    mpd_host_model host (.sys_clk_i, .req_i(req),
        .pins_o(pins));
    mpd_ctrl DUT (.sys_clk_i, .arst_n_i, .supply_ok_i, .gate_supply_ok_i, .sleep_ctl_n_i,
        .brake_in_n_i, .pwm_i, .dir_i, .hall_i, .gates_o, .ready_o);
    task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic set_req(input logic [3:0] r);
        @(posedge sys_clk_i);
        req <= r;
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    // Phase table for one direction, other is swapped
    function automatic logic [6:0] expect_run(input logic [2:0] h, input logic d, input logic p);
        logic [1:0] hi, lo;
        case (h)
            3'b101: {hi, lo} = 4'h2;
            3'b100: {hi, lo} = 4'h6;
            3'b110: {hi, lo} = 4'h4;
            3'b010: {hi, lo} = 4'h8;
            3'b011: {hi, lo} = 4'h9;
            default: {hi, lo} = 4'h1;
        endcase
        if (!d) {hi, lo} = {lo, hi};
        return 7'h40 | (7'h01 << lo) | (p ? 7'h08 << hi : 7'h01 << hi);
    endfunction
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 110000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        int w;
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i) arst_n_i = 1'b1;
        set_req(4'hC);
        @(negedge sys_clk_i) gate_supply_ok_i = 1'b1;
        run(50);
        check("no supply", {ready_o, gates_o}, 7'h00);
        @(negedge sys_clk_i) {supply_ok_i, gate_supply_ok_i} = 2'b10;
        run(50);
        check("no gate supply", {ready_o, gates_o}, 7'h00);
        @(negedge sys_clk_i) gate_supply_ok_i = 1'b1;
        for (w = 0; w < 105000 && ready_o !== 1'b1; w++) @(negedge sys_clk_i);
        check("power-up", {5'h00, ready_o, w >= 100000 && w <= 200000}, 7'h03);
        $display("test power-up done");
        set_req(4'hA);
        run(8);
        check("brake", {ready_o, gates_o}, 7'h47);
        $display("test brake done");
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < 6; i++) begin
                @(negedge sys_clk_i) hall_i = seq[i];
                set_req({3'b111, d[0]});
                run(6);
                check("pulse", {ready_o, gates_o}, expect_run(seq[i], d[0], 1'b0));
                run(110);
                check("high", {ready_o, gates_o}, expect_run(seq[i], d[0], 1'b1));
                set_req({3'b110, d[0]});
                run(6);
                check("low", {ready_o, gates_o}, expect_run(seq[i], d[0], 1'b0));
            end
        end
        $display("test table done");
        set_req(4'h6);
        run(6);
        check("sleep", {ready_o, gates_o}, 7'h00);
        set_req(4'h2);
        @(negedge sys_clk_i) hall_i = 3'b100;
        run(6);
        check("sleep inputs", {ready_o, gates_o}, 7'h00);
        set_req(4'hE);
        run(100);
        check("wake", {ready_o, gates_o}, 7'h00);
        $display("test sleep done");
        close_out();
    end
endmodule // mpd_ctrl_tb
